// >>> core/vod_count_mem.sv
// switching counter store with registered read data
`timescale 1ns/1ps
module vod_count_mem #(
   parameter int W = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic we_i, // write strobe
   input wire logic [AW-1:0] waddr_i, // write address
   input wire logic [W-1:0] wdata_i, // write data
   input wire logic [AW-1:0] raddr_i, // read address
   output logic [W-1:0] rdata_o // read data, one cycle later
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } vod_mem_st_t;

   vod_mem_st_t q, d;

   always_comb begin
      d = q;
      d.rdata = q.mem[raddr_i];
      if (we_i) begin
         d.mem[waddr_i] = wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
endmodule

// >>> core/vod_diag_top.sv
// valve output diagnostics, safe-state outputs and switching counters
`timescale 1ns/1ps
`include "vod_cfg.svh"
module vod_diag_top #(
   parameter int NCH = 8,
   parameter int AW = 3,
   parameter int CW = 32,
   parameter int unsigned SAVE_CYC = `VOD_SAVE_TIME_S * `VOD_CLK_HZ
) (
   input wire logic ref_clk_i, // 40 MHz system clock
   input wire logic rst_n_i, // power-on reset, async, active low
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [7:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready
   output logic pslverr_o, // apb error, unmapped address
   input wire logic ht_wr_i, // handheld parameter write strobe
   input wire logic [7:0] ht_addr_i, // handheld register address
   input wire logic [31:0] ht_wdata_i, // handheld write data
   input wire logic ctrl_ov_i, // control supply over-voltage pin
   input wire logic ctrl_uv_i, // control supply under-voltage pin
   input wire logic out_ov_i, // output supply over-voltage pin
   input wire logic out_uv_i, // output supply under-voltage pin
   input wire logic short_i, // valve short detected pin
   input wire logic [NCH-1:0] open_i, // per-channel open detected pins
   input wire logic switch_hold_i, // unit switch: 1 hold, 0 off
   input wire logic comm_fault_i, // fieldbus communication fault
   input wire logic comm_idle_i, // fieldbus communication idle
   input wire logic [NCH-1:0] valve_cmd_i, // valve data from fieldbus
   input wire logic nv_load_i, // restore a saved count
   input wire logic [AW-1:0] nv_load_ch_i, // channel of restored count
   input wire logic [CW-1:0] nv_load_data_i, // restored count
   output logic nv_save_o, // save strobe, one cycle
   output logic [AW-1:0] nv_save_ch_o, // channel being saved
   output logic [CW-1:0] nv_save_data_o, // count being saved
   output logic [NCH-1:0] valve_o, // valve drive
   output logic ctrl_supply_err_o, // control supply error
   output logic out_supply_err_o, // output supply error
   output logic short_err_o, // unit short error
   output logic [NCH-1:0] open_err_o, // per-channel open error
   output logic [NCH-1:0] count_err_o, // per-channel count error
   output logic irq_o // level interrupt
);
   localparam int EW = 3 + 2 * NCH;

   typedef struct packed {
      logic [3:0] sup1;
      logic [3:0] sup2;
      logic sh1;
      logic sh2;
      logic [NCH-1:0] op1;
      logic [NCH-1:0] op2;
      logic sw1;
      logic sw2;
      logic [`VOD_CTRL_W-1:0] ctrl;
      logic [2*NCH-1:0] fact;
      logic [2*NCH-1:0] iact;
      logic [15:0] limit;
      logic [EW-1:0] mask;
      logic [EW-1:0] stat;
      logic [EW-1:0] err;
      logic short_lat;
      logic [NCH-1:0] valve;
      logic [NCH-1:0] pend;
      vod_pkg::vod_scan_t sc;
      logic [AW-1:0] idx;
      logic [31:0] tmr;
      logic save_arm;
      logic saving;
      logic nv_save;
      logic [AW-1:0] nv_ch;
      logic [CW-1:0] nv_data;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic ld_byp;
      logic [CW-1:0] ld_val;
   } vod_st_t;

   vod_st_t q, d;
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [CW-1:0] mem_wd;
   logic [CW-1:0] mem_rd;

   vod_count_mem #(
      .W(CW),
      .DEPTH(NCH),
      .AW(AW)
   ) u_mem (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .we_i(mem_we),
      .waddr_i(mem_wa),
      .wdata_i(mem_wd),
      .raddr_i(q.idx),
      .rdata_o(mem_rd)
   );

   // only the seven word offsets of the map answer without error
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `VOD_OFS_CTRL) || (a == `VOD_OFS_FAULT_ACT) ||
         (a == `VOD_OFS_IDLE_ACT) || (a == `VOD_OFS_LIMIT) ||
         (a == `VOD_OFS_ERR) || (a == `VOD_OFS_IRQ_STAT) ||
         (a == `VOD_OFS_IRQ_MASK);
   endfunction

   // ***********************************
   // parameter write, shared by bus and handheld
   // ***********************************
   function automatic vod_st_t wr_reg(input vod_st_t s, input logic [7:0] a,
      input logic [31:0] v);
      vod_st_t r;
      r = s;
      case (a)
         `VOD_OFS_CTRL: begin
            r.ctrl = v[`VOD_CTRL_W-1:0];
         end
         `VOD_OFS_FAULT_ACT: begin
            r.fact = v[2*NCH-1:0];
         end
         `VOD_OFS_IDLE_ACT: begin
            r.iact = v[2*NCH-1:0];
         end
         `VOD_OFS_LIMIT: begin
            // out-of-range limits are refused, old value kept
            if (v[15:0] >= `VOD_LIMIT_MIN && v[15:0] <= `VOD_LIMIT_MAX &&
               v[31:16] == 16'h0000) begin
               r.limit = v[15:0];
            end
         end
         `VOD_OFS_IRQ_MASK: begin
            r.mask = v[EW-1:0];
         end
         default: begin
            r = s;
         end
      endcase
      return r;
   endfunction

   // ***********************************
   // next state
   // ***********************************
   logic ctrl_bad;
   logic out_bad;
   logic short_now;
   logic [EW-1:0] err_n;
   logic [EW-1:0] w1c;
   logic [NCH-1:0] valve_n;
   logic [NCH-1:0] rise;
   logic [NCH-1:0] cnt_err_n;
   logic [CW-1:0] cnt_new;
   logic [CW-1:0] cnt_base;
   logic tmr_hit;
   logic [31:0] lim_full;
   logic bus_acc;
   logic bus_done;
   logic sc_take;
   vod_pkg::vod_act_t act;

   always_comb begin
      d = q;
      act = vod_pkg::VOD_ACT_CLEAR;
      w1c = '0;
      cnt_new = mem_rd;
      mem_we = 1'b0;
      mem_wa = q.idx;
      mem_wd = mem_rd;
      sc_take = 1'b0;
      d.nv_save = 1'b0;

      // pins pass two flops before use
      d.sup1 = {out_uv_i, out_ov_i, ctrl_uv_i, ctrl_ov_i};
      d.sup2 = q.sup1;
      d.sh1 = short_i;
      d.sh2 = q.sh1;
      d.op1 = open_i;
      d.op2 = q.op1;
      // the unit switch is a pin too, so it is synchronised like the detectors
      d.sw1 = switch_hold_i;
      d.sw2 = q.sw1;

      // apb: one wait state, write lands on the ready edge
      bus_acc = psel_i && penable_i && !q.pready;
      bus_done = psel_i && penable_i && q.pready;
      d.pready = bus_acc;
      if (bus_acc) begin
         d.pslverr = !mapped(paddr_i);
         // an unmapped read gives zero with the error flag set
         case (paddr_i)
            `VOD_OFS_CTRL: d.prdata = 32'(q.ctrl);
            `VOD_OFS_FAULT_ACT: d.prdata = 32'(q.fact);
            `VOD_OFS_IDLE_ACT: d.prdata = 32'(q.iact);
            `VOD_OFS_LIMIT: d.prdata = 32'(q.limit);
            `VOD_OFS_ERR: d.prdata = 32'(q.err);
            `VOD_OFS_IRQ_STAT: d.prdata = 32'(q.stat);
            `VOD_OFS_IRQ_MASK: d.prdata = 32'(q.mask);
            default: d.prdata = 32'h0000_0000;
         endcase
      end
      if (bus_done && pwrite_i) begin
         d = wr_reg(d, paddr_i, pwdata_i);
         if (paddr_i == `VOD_OFS_IRQ_STAT) begin
            w1c = pwdata_i[EW-1:0];
         end
      end
      // same-cycle collision: handheld applied last
      if (ht_wr_i) begin
         d = wr_reg(d, ht_addr_i, ht_wdata_i);
      end

      // ***********************************
      // supply and short diagnostics
      // ***********************************
      ctrl_bad = q.sup2[0] | q.sup2[1];
      out_bad = q.sup2[2] | q.sup2[3];
      short_now = q.ctrl[`VOD_B_SHORT_EN] & q.sh2;
      // latch cleared only by power-on reset
      if (short_now && q.ctrl[`VOD_B_SHORT_MANUAL]) begin
         d.short_lat = 1'b1;
      end
      // each flag is its synchronised detector gated by its enable, the short flag or-ed with the manual latch
      err_n = '0;
      err_n[`VOD_E_CTRL] = q.ctrl[`VOD_B_CTRL_WATCH] & ctrl_bad;
      err_n[`VOD_E_OUT] = q.ctrl[`VOD_B_OUT_WATCH] & out_bad;
      err_n[`VOD_E_SHORT] = q.ctrl[`VOD_B_SHORT_EN] &
         (short_now | (q.ctrl[`VOD_B_SHORT_MANUAL] & q.short_lat));
      err_n[`VOD_E_OPEN +: NCH] = {NCH{q.ctrl[`VOD_B_OPEN_EN]}} & q.op2;

      // ***********************************
      // channel outputs: fault over idle over data
      // ***********************************
      for (int c = 0; c < NCH; c++) begin
         if (comm_fault_i || comm_idle_i) begin
            if (q.ctrl[`VOD_B_HANDHELD]) begin
               act = vod_pkg::vod_act_t'(comm_fault_i ?
                  q.fact[2*c +: 2] : q.iact[2*c +: 2]);
            end else begin
               act = q.sw2 ? vod_pkg::VOD_ACT_HOLD : vod_pkg::VOD_ACT_CLEAR;
            end
            // hold repeats the drive of the cycle before the event
            case (act)
               vod_pkg::VOD_ACT_HOLD: valve_n[c] = q.valve[c];
               vod_pkg::VOD_ACT_FORCE: valve_n[c] = 1'b1;
               default: valve_n[c] = 1'b0;
            endcase
         end else begin
            valve_n[c] = valve_cmd_i[c];
         end
      end
      d.valve = valve_n;
      rise = valve_n & ~q.valve;

      // ***********************************
      // switching counters: one channel per two cycles
      // ***********************************
      lim_full = 32'(q.limit) * `VOD_LIMIT_SCALE;
      cnt_err_n = q.err[`VOD_E_OPEN + NCH +: NCH];
      // the store reads a cycle ahead: a restore into the channel under scan
      // would be lost, so its value is forwarded into the take cycle
      d.ld_byp = nv_load_i && (nv_load_ch_i == q.idx);
      d.ld_val = nv_load_data_i;
      cnt_base = q.ld_byp ? q.ld_val : mem_rd;
      tmr_hit = (q.tmr >= SAVE_CYC - 1);
      if (tmr_hit) begin
         d.tmr = 32'h0000_0000;
         d.save_arm = 1'b1;
      end else begin
         d.tmr = q.tmr + 32'h0000_0001;
      end
      case (q.sc)
         vod_pkg::VOD_SC_RD: begin
            d.sc = vod_pkg::VOD_SC_WR;
         end
         vod_pkg::VOD_SC_WR: begin
            sc_take = q.pend[q.idx] && !nv_load_i;
            cnt_new = cnt_base + CW'(sc_take);
            mem_we = sc_take;
            cnt_err_n[q.idx] = q.ctrl[`VOD_B_COUNT_EN] &&
               (32'(cnt_new) > lim_full);
            if (q.saving || (q.save_arm && q.idx == '0)) begin
               d.nv_save = 1'b1;
               d.nv_ch = q.idx;
               d.nv_data = cnt_new;
               d.saving = (q.idx != AW'(NCH - 1));
               // a period that ends on the opening save of a sweep is kept
               d.save_arm = tmr_hit || (q.save_arm && q.saving);
            end
            d.idx = (q.idx == AW'(NCH - 1)) ? '0 : q.idx + AW'(1);
            d.sc = vod_pkg::VOD_SC_RD;
         end
         default: begin
            d.sc = vod_pkg::VOD_SC_RD;
         end
      endcase
      mem_wd = cnt_new;
      // restored count wins the write port; counting resumes from it
      if (nv_load_i) begin
         mem_we = 1'b1;
         mem_wa = nv_load_ch_i;
         mem_wd = nv_load_data_i;
      end
      // a turn-on in the take cycle stays pending
      for (int c = 0; c < NCH; c++) begin
         d.pend[c] = (q.pend[c] & ~(sc_take && q.idx == AW'(c))) | rise[c];
      end
      err_n[`VOD_E_OPEN + NCH +: NCH] = cnt_err_n & {NCH{q.ctrl[`VOD_B_COUNT_EN]}};

      // ***********************************
      // interrupt: rising errors are sticky, set wins over clear
      // ***********************************
      d.err = err_n;
      d.stat = (q.stat & ~w1c) | (err_n & ~q.err);
      d.irq = |(d.stat & d.mask);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.ctrl <= `VOD_CTRL_RST;
         q.limit <= `VOD_LIMIT_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   assign nv_save_o = q.nv_save;
   assign nv_save_ch_o = q.nv_ch;
   assign nv_save_data_o = q.nv_data;
   assign valve_o = q.valve;
   assign ctrl_supply_err_o = q.err[`VOD_E_CTRL];
   assign out_supply_err_o = q.err[`VOD_E_OUT];
   assign short_err_o = q.err[`VOD_E_SHORT];
   assign open_err_o = q.err[`VOD_E_OPEN +: NCH];
   assign count_err_o = q.err[`VOD_E_OPEN + NCH +: NCH];
   assign irq_o = q.irq;
endmodule

// >>> pkg/vod_cfg.svh
// constants for the valve output diagnostic block
`ifndef VOD_CFG_SVH
`define VOD_CFG_SVH

// ***********************************
// register map (byte addresses)
// ***********************************
`define VOD_OFS_CTRL 8'h00
`define VOD_OFS_FAULT_ACT 8'h04
`define VOD_OFS_IDLE_ACT 8'h08
`define VOD_OFS_LIMIT 8'h0C
`define VOD_OFS_ERR 8'h10
`define VOD_OFS_IRQ_STAT 8'h14
`define VOD_OFS_IRQ_MASK 8'h18

// ***********************************
// control fields and reset values
// ***********************************
`define VOD_CTRL_W 7
`define VOD_B_CTRL_WATCH 0
`define VOD_B_OUT_WATCH 1
`define VOD_B_SHORT_EN 2
`define VOD_B_SHORT_MANUAL 3
`define VOD_B_OPEN_EN 4
`define VOD_B_COUNT_EN 5
`define VOD_B_HANDHELD 6
`define VOD_CTRL_RST 7'h07
`define VOD_LIMIT_MIN 16'h0001
`define VOD_LIMIT_MAX 16'hFDE8
`define VOD_LIMIT_RST 16'hFDE8
`define VOD_LIMIT_SCALE 32'h0000_03E8

// ***********************************
// error vector layout
// ***********************************
`define VOD_E_CTRL 0
`define VOD_E_OUT 1
`define VOD_E_SHORT 2
`define VOD_E_OPEN 3

// ***********************************
// timing
// ***********************************
`define VOD_CLK_HZ 40000000
`define VOD_SAVE_TIME_S 30

`endif

// >>> pkg/vod_pkg.sv
// shared types of the valve output diagnostic block
package vod_pkg;
   typedef enum logic [1:0] {
      VOD_ACT_CLEAR = 2'b00,
      VOD_ACT_HOLD = 2'b01,
      VOD_ACT_FORCE = 2'b10
   } vod_act_t;

   typedef enum logic {
      VOD_SC_RD = 1'b0,
      VOD_SC_WR = 1'b1
   } vod_scan_t;
endpackage

// >>> testbench/test_vod_diag_top.sv
// self-checking testbench for the valve output diagnostic block
`timescale 1ns/1ps
`include "vod_cfg.svh"
`define AT @(posedge ref_clk_i)
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module test_vod_diag_top;
   logic ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, ht_wr_i, nv_load_i, short_req;
   logic comm_fault_i, comm_idle_i, switch_hold_i, short_i, pready_o, pslverr_o, irq_o;
   logic nv_save_o, ctrl_supply_err_o, out_supply_err_o, short_err_o;
   logic [7:0] paddr_i, ht_addr_i, valve_cmd_i, open_req, open_i, valve_o, open_err_o;
   logic [7:0] count_err_o;
   logic [31:0] pwdata_i, ht_wdata_i, prdata_o, nv_load_data_i, nv_save_data_o;
   logic [31:0] store [8];
   logic [3:0] volt;
   logic [2:0] nv_load_ch_i, nv_save_ch_o;
   int error_cnt, total_checks;

   // short save period keeps the run brief
   vod_diag_top #(.SAVE_CYC(200)) dut_u (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .ht_wr_i(ht_wr_i), .ht_addr_i(ht_addr_i),
      .ht_wdata_i(ht_wdata_i), .ctrl_ov_i(volt[0]), .ctrl_uv_i(volt[1]), .out_ov_i(volt[2]),
      .out_uv_i(volt[3]), .short_i(short_i), .open_i(open_i), .switch_hold_i(switch_hold_i),
      .comm_fault_i(comm_fault_i), .comm_idle_i(comm_idle_i), .valve_cmd_i(valve_cmd_i),
      .nv_load_i(nv_load_i), .nv_load_ch_i(nv_load_ch_i), .nv_load_data_i(nv_load_data_i),
      .nv_save_o(nv_save_o), .nv_save_ch_o(nv_save_ch_o), .nv_save_data_o(nv_save_data_o),
      .valve_o(valve_o), .ctrl_supply_err_o(ctrl_supply_err_o),
      .out_supply_err_o(out_supply_err_o), .short_err_o(short_err_o),
      .open_err_o(open_err_o), .count_err_o(count_err_o), .irq_o(irq_o));
   vod_valve_model model_u (
      .ref_clk_i(ref_clk_i), .short_req_i(short_req), .open_req_i(open_req),
      .save_i(nv_save_o), .save_ch_i(nv_save_ch_o), .save_data_i(nv_save_data_o),
      .short_o(short_i), .open_o(open_i), .store_o(store));

   // ***********************************
   // bus tasks
   // ***********************************
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic xe);
      `AT;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      `AT;
      penable_i <= 1'b1;
      // no cycle count assumed: a missing ready is left to the watchdog
      do begin
         @(negedge ref_clk_i);
      end while (pready_o !== 1'b1);
      `AT;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (!w) `CHK({pslverr_o, prdata_o}, {xe, x})
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, x, 1'b0);
   endtask
   task automatic ht(input logic [7:0] a, input logic [31:0] d);
      `AT;
      ht_wr_i <= 1'b1;
      ht_addr_i <= a;
      ht_wdata_i <= d;
      `AT;
      ht_wr_i <= 1'b0;
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      repeat (20000) `AT;
      error_cnt++;
      conclude();
   end
   initial begin
      {psel_i, penable_i, pwrite_i, ht_wr_i, nv_load_i, short_req, comm_fault_i} = '0;
      {comm_idle_i, switch_hold_i, volt, open_req, valve_cmd_i} = '0;
      {paddr_i, ht_addr_i, pwdata_i, ht_wdata_i, nv_load_ch_i, nv_load_data_i} = '0;
      rst_n_i = 1'b0;
      repeat (10) `AT;
      rst_n_i <= 1'b1;
      rd(`VOD_OFS_CTRL, 32'h7);
      rd(`VOD_OFS_LIMIT, 32'hFDE8);
      rd(`VOD_OFS_FAULT_ACT, 32'h0);
      apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         `AT volt <= 4'h1 << i;
         cyc(5);
         `CHK({out_supply_err_o, ctrl_supply_err_o}, (i < 2) ? 2'b01 : 2'b10)
         `AT volt <= 4'h0;
         cyc(5);
      end
      wr(`VOD_OFS_CTRL, 32'h4);
      `AT volt <= 4'hF;
      cyc(5);
      `CHK({out_supply_err_o, ctrl_supply_err_o}, 2'b00)
      wr(`VOD_OFS_CTRL, 32'h7);
      cyc(5);
      rd(`VOD_OFS_ERR, 32'h3);
      rd(`VOD_OFS_IRQ_STAT, 32'h3);
      `CHK(irq_o, 1'b0)
      wr(`VOD_OFS_IRQ_MASK, 32'h1);
      cyc(2);
      `CHK(irq_o, 1'b1)
      wr(`VOD_OFS_IRQ_STAT, 32'h3);
      cyc(2);
      `CHK(irq_o, 1'b0)
      `AT volt <= 4'h0;
      `AT short_req <= 1'b1;
      cyc(5);
      `CHK(short_err_o, 1'b1)
      `AT short_req <= 1'b0;
      cyc(5);
      `CHK(short_err_o, 1'b0)
      wr(`VOD_OFS_CTRL, 32'hF);
      `AT short_req <= 1'b1;
      cyc(5);
      `AT short_req <= 1'b0;
      cyc(5);
      `CHK(short_err_o, 1'b1)
      wr(`VOD_OFS_CTRL, 32'hB);
      cyc(2);
      `CHK(short_err_o, 1'b0)
      // power cycle: the only way out of a latched short
      `AT rst_n_i <= 1'b0;
      cyc(2);
      `AT rst_n_i <= 1'b1;
      cyc(2);
      `CHK(short_err_o, 1'b0)
      `AT open_req <= 8'h04;
      cyc(5);
      `CHK(open_err_o, 8'h00)
      wr(`VOD_OFS_CTRL, 32'h17);
      cyc(5);
      `CHK(open_err_o, 8'h04)
      rd(`VOD_OFS_ERR, 32'h20);
      `AT open_req <= 8'h00;
      wr(`VOD_OFS_FAULT_ACT, 32'hE4);
      `AT valve_cmd_i <= 8'h03;
      cyc(2);
      `CHK(valve_o, 8'h03)
      `AT comm_fault_i <= 1'b1;
      cyc(2);
      `CHK(valve_o, 8'h00)
      `AT comm_fault_i <= 1'b0;
      switch_hold_i <= 1'b1;
      cyc(4);
      `AT comm_fault_i <= 1'b1;
      valve_cmd_i <= 8'h00;
      cyc(2);
      `CHK(valve_o, 8'h03)
      `AT comm_fault_i <= 1'b0;
      valve_cmd_i <= 8'h03;
      wr(`VOD_OFS_CTRL, 32'h47);
      `AT comm_fault_i <= 1'b1;
      cyc(2);
      `CHK(valve_o, 8'h06)
      ht(`VOD_OFS_IDLE_ACT, 32'hAAAA);
      rd(`VOD_OFS_IDLE_ACT, 32'hAAAA);
      `AT comm_idle_i <= 1'b1;
      cyc(2);
      `CHK(valve_o, 8'h06)
      `AT comm_fault_i <= 1'b0;
      cyc(2);
      `CHK(valve_o, 8'hFF)
      `AT comm_idle_i <= 1'b0;
      valve_cmd_i <= 8'h00;
      switch_hold_i <= 1'b0;
      // out-of-range limits must leave the old value in place
      wr(`VOD_OFS_LIMIT, 32'h0);
      wr(`VOD_OFS_LIMIT, 32'h0000_FDE9);
      rd(`VOD_OFS_LIMIT, 32'hFDE8);
      wr(`VOD_OFS_LIMIT, 32'h1);
      rd(`VOD_OFS_LIMIT, 32'h1);
      wr(`VOD_OFS_CTRL, 32'h27);
      `AT nv_load_i <= 1'b1;
      nv_load_ch_i <= 3'h1;
      nv_load_data_i <= 32'h0000_03E8;
      `AT nv_load_i <= 1'b0;
      cyc(40);
      `CHK(count_err_o, 8'h00)
      `AT valve_cmd_i <= 8'h02;
      cyc(4);
      `AT valve_cmd_i <= 8'h00;
      cyc(40);
      `CHK(count_err_o, 8'h02)
      rd(`VOD_OFS_ERR, 32'h1000);
      wr(`VOD_OFS_LIMIT, 32'h2);
      cyc(40);
      `CHK(count_err_o, 8'h00)
      cyc(450);
      `CHK(store[1], 32'h0000_03E9)
      `CHK(store[7], 32'h0000_0001)
      conclude();
   end
endmodule

// >>> testbench/vod_diag_props.sv
// assertion checker for the valve output diagnostic block
`timescale 1ns/1ps
module vod_diag_props #(
   parameter int AW = 3,
   parameter int NCH = 8
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic [7:0] paddr_i, // apb address
   input wire logic pready_o, // apb ready
   input wire logic pslverr_o, // apb error
   input wire logic ctrl_ov_i, // control supply high
   input wire logic ctrl_uv_i, // control supply low
   input wire logic short_i, // short level
   input wire logic [NCH-1:0] open_i, // open levels
   input wire logic comm_fault_i, // comm fault
   input wire logic comm_idle_i, // comm idle
   input wire logic [NCH-1:0] valve_cmd_i, // valve data
   input wire logic [NCH-1:0] valve_o, // valve drive
   input wire logic ctrl_supply_err_o, // supply error
   input wire logic short_err_o, // short error
   input wire logic [NCH-1:0] open_err_o, // open errors
   input wire logic nv_save_o, // save strobe
   input wire logic [AW-1:0] nv_save_ch_o // save channel
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // a quiet supply for four edges outlasts the synchroniser
   property p_ctrl_ok;
      (!ctrl_ov_i && !ctrl_uv_i) [*4] |-> !ctrl_supply_err_o;
   endproperty
   a_ctrl_ok: assert property (p_ctrl_ok)
      else $error("supply error without a cause");
   property p_short_cause;
      $rose(short_err_o) |-> $past(short_i, 3) || $past(short_i, 2);
   endproperty
   a_short_cause: assert property (p_short_cause)
      else $error("short error without a short");
   property p_open_cause;
      (open_err_o & ~$past(open_err_o) & ~($past(open_i, 3) | $past(open_i, 2))) == '0;
   endproperty
   a_open_cause: assert property (p_open_cause)
      else $error("open error without an open");
   property p_follow;
      !comm_fault_i && !comm_idle_i |=> valve_o == $past(valve_cmd_i);
   endproperty
   a_follow: assert property (p_follow)
      else $error("valve drive does not follow data");
   property p_save_gap;
      nv_save_o |=> !nv_save_o;
   endproperty
   a_save_gap: assert property (p_save_gap)
      else $error("save strobe too long");
   property p_save_seq;
      nv_save_o && nv_save_ch_o != '0 |->
         $past(nv_save_o, 2) && nv_save_ch_o == AW'($past(nv_save_ch_o, 2) + 1'b1);
   endproperty
   a_save_seq: assert property (p_save_seq)
      else $error("save sweep out of order");
   property p_apb_wait;
      psel_i && penable_i && !pready_o |=> pready_o;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("ready late");
   property p_rdy_pulse;
      pready_o |=> !pready_o;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("ready held too long");
   property p_apb_err;
      pready_o && paddr_i > 8'h18 |-> pslverr_o;
   endproperty
   a_apb_err: assert property (p_apb_err)
      else $error("unmapped access not refused");
   c_short: cover property ($rose(short_err_o));
   c_save: cover property (nv_save_o && nv_save_ch_o == AW'(NCH - 1));
   c_err: cover property (pready_o && pslverr_o);
endmodule

bind vod_diag_top vod_diag_props #(.AW(AW), .NCH(NCH)) u_props (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .ctrl_ov_i(ctrl_ov_i),
   .ctrl_uv_i(ctrl_uv_i), .short_i(short_i), .open_i(open_i), .comm_fault_i(comm_fault_i),
   .comm_idle_i(comm_idle_i), .valve_cmd_i(valve_cmd_i), .valve_o(valve_o),
   .ctrl_supply_err_o(ctrl_supply_err_o), .short_err_o(short_err_o),
   .open_err_o(open_err_o), .nv_save_o(nv_save_o), .nv_save_ch_o(nv_save_ch_o)
);

// >>> testbench/vod_valve_model.sv
// far-side model: valves with injectable faults and a count store
`timescale 1ns/1ps
module vod_valve_model #(
   parameter int NCH = 8,
   parameter int AW = 3,
   parameter int CW = 32
) (
   input wire logic ref_clk_i, // clock
   input wire logic short_req_i, // inject a shorted coil
   input wire logic [NCH-1:0] open_req_i, // inject broken leads
   input wire logic save_i, // save strobe
   input wire logic [AW-1:0] save_ch_i, // save channel
   input wire logic [CW-1:0] save_data_i, // save data
   output logic short_o, // short comparator level
   output logic [NCH-1:0] open_o, // open comparator levels
   output logic [CW-1:0] store_o [NCH] // kept counts
);
   // raw unsynchronised levels, as a comparator would give
   assign short_o = short_req_i;
   assign open_o = open_req_i;
   always_ff @(posedge ref_clk_i) begin
      if (save_i) begin
         store_o[save_ch_i] <= save_data_i;
      end
   end
endmodule
